// ### common/frps_pkg.sv
// Overview of operation
// - Start after enable and rails good 10ms
// - All turn-on ramps start together
// - Each drive turns on at own delay
// - Turn-on timer clears after threshold
// - Complete released 160ms after all full
// - Rail low over 30us is fault
// - Fault drops complete, shutdown, all drives strong
// - Enable off without fault drops complete
// - Turn-off ramps together, latch per channel
// - Weak discharge, strong below low threshold
// - Enable polarity is a build option
// - Active-high option sleeps while enable low and idle
// - Open-drain option gives logic outputs
// - Voltage mode turns channels on independently
// - Voltage mode releases complete after 150ms
// - Voltage mode drops only failed channel
// - Voltage mode disable latches low, ordered off
// - Shutdown line low forces everything off
// - Shutdown release skips qualification wait
// - Restart after fault is automatic
package frps_pkg;
    localparam int CLK_MHZ       = 250;
    localparam int QUAL_MS       = 10;
    localparam int QUAL_CYC      = QUAL_MS * 1000 * CLK_MHZ;
    localparam int DONE_MS       = 160;
    localparam int DONE_CYC      = DONE_MS * 1000 * CLK_MHZ;
    localparam int VDONE_MS      = 150;
    localparam int VDONE_CYC     = VDONE_MS * 1000 * CLK_MHZ;
    localparam int FILT_US       = 30;
    localparam int FILT_CYC      = FILT_US * CLK_MHZ;
    localparam int TMR_W         = 32;
    localparam int DLY_W         = 24;
    localparam int CH            = 4;
    typedef enum logic [2:0] {
        FRPS_IDLE = 3'b000,
        FRPS_QUAL = 3'b001,
        FRPS_RAMP = 3'b011,
        FRPS_SETL = 3'b010,
        FRPS_RUN  = 3'b110,
        FRPS_OFF  = 3'b111,
        FRPS_FLT  = 3'b101
    } frps_state_t;
endpackage

// ### verilog/frps_sync.sv
`timescale 1ns/100ps
`default_nettype none
module frps_sync
    import frps_pkg::*;
#(
    parameter int           W    = 1,
    // Reset value per bit is the idle level of that pin, so release shows no false edge
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Data
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    logic [W-1:0] s1_ff;
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_ff <= INIT;
            dout  <= INIT;
        end else begin
            s1_ff <= din;
            dout  <= s1_ff;
        end
    end
endmodule
`default_nettype wire

// ### verilog/frps_timer.sv
`timescale 1ns/100ps
`default_nettype none
module frps_timer
    import frps_pkg::*;
#(
    parameter int W = 24
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Control
    input  wire logic         run,
    input  wire logic [W-1:0] limit,
    output var  logic         done
);
    // Counter clears whenever run drops, ready for the next sequence
    logic [W-1:0] cnt_ff;
    wire          at_end = (cnt_ff >= limit);
    always_ff @(posedge clk) begin
        if (reset || !run) begin
            cnt_ff <= '0;
            done   <= 1'b0;
        end else begin
            cnt_ff <= at_end ? cnt_ff : cnt_ff + 1'b1;
            done   <= at_end;
        end
    end
endmodule
`default_nettype wire

// ### verilog/frps_seq.sv
`timescale 1ns/100ps
`default_nettype none
module frps_seq
    import frps_pkg::*;
#(
    parameter bit         EN_ACT_HIGH = 1'b1,
    parameter bit         VOLT_MODE   = 1'b0,
    parameter bit         OPEN_DRAIN  = 1'b0,
    parameter int         QUAL_N      = QUAL_CYC,
    parameter int         DONE_N      = DONE_CYC,
    parameter int         VDONE_N     = VDONE_CYC,
    parameter int         FILT_N      = FILT_CYC
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // Pins in
    input  wire logic                 enable_pin,
    input  wire logic [CH-1:0]        rail_undervoltage_sense,
    input  wire logic                 shared_shutdown_line_in,
    // Analog drive stage status
    input  wire logic [CH-1:0]        drive_at_full,
    input  wire logic [CH-1:0]        drive_below_low,
    // Delay programming
    input  wire logic [CH*DLY_W-1:0]  turn_on_delay_ramp,
    input  wire logic [CH*DLY_W-1:0]  turn_off_delay_ramp,
    // Outputs
    output var  logic [CH-1:0]        drive_on,
    output var  logic [CH-1:0]        drive_weak_off,
    output var  logic [CH-1:0]        drive_strong_off,
    output var  logic [CH-1:0]        logic_out,
    output var  logic [CH-1:0]        logic_out_oe,
    output var  logic                 seq_done_n,
    output var  logic                 shared_shutdown_line_out,
    output var  logic                 shared_shutdown_line_oe,
    output var  logic                 sleep
);
    // ****************************************
    // Input synchronisation
    // ****************************************
    logic [CH-1:0] rail_s, full_s, low_s;
    logic          en_s, sys_s;
    // Enable resets to its inactive level and the shared line to high: no fake start or kill
    frps_sync #(.W(2*CH+CH+2), .INIT({{3*CH{1'b0}}, ~EN_ACT_HIGH, 1'b1})) u_sync (
        .clk   (clk),
        .reset (reset),
        .din   ({rail_undervoltage_sense, drive_at_full, drive_below_low,
                 enable_pin, shared_shutdown_line_in}),
        .dout  ({rail_s, full_s, low_s, en_s, sys_s})
    );
    wire en_ok   = EN_ACT_HIGH ? en_s : ~en_s;
    wire all_ok  = &rail_s;
    wire sys_low = ~sys_s;

    // ****************************************
    // Glitch filter per rail
    // ****************************************
    logic [CH-1:0] rail_flt;
    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_filt
            logic [15:0] fc_ff;
            always_ff @(posedge clk) begin
                if (reset || rail_s[g]) begin
                    fc_ff <= '0;
                end else if (fc_ff < 16'(FILT_N)) begin
                    fc_ff <= fc_ff + 16'h0001;
                end
            end
            assign rail_flt[g] = (fc_ff >= 16'(FILT_N));
        end
    endgenerate
    wire any_flt = |rail_flt;

    // ****************************************
    // Sequence state
    // ****************************************
    frps_state_t   st_ff, nxt_st;
    logic [TMR_W-1:0] tm_ff;
    logic          sys_d_ff;
    logic [CH-1:0] on_ff, off_latch_ff, strong_ff;
    logic          done_n_ff, sdn_ff;
    wire  [CH-1:0] on_done, off_done;
    wire  [TMR_W-1:0] tm_lim = VOLT_MODE ? TMR_W'(VDONE_N) :
                               (st_ff == FRPS_QUAL) ? TMR_W'(QUAL_N) : TMR_W'(DONE_N);
    wire  tm_hit  = (tm_ff >= tm_lim);
    wire  sys_rel = sys_s & ~sys_d_ff;
    wire  all_full = &full_s;

    generate
        for (g = 0; g < CH; g++) begin : g_tmr
            frps_timer #(.W(DLY_W)) u_on (
                .clk   (clk),
                .reset (reset),
                .run   (st_ff == FRPS_RAMP && !on_ff[g]),
                .limit (turn_on_delay_ramp[g*DLY_W +: DLY_W]),
                .done  (on_done[g])
            );
            frps_timer #(.W(DLY_W)) u_off (
                .clk   (clk),
                .reset (reset),
                .run   (st_ff == FRPS_OFF),
                .limit (turn_off_delay_ramp[g*DLY_W +: DLY_W]),
                .done  (off_done[g])
            );
        end
    endgenerate

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            FRPS_IDLE: begin
                if (en_ok && (VOLT_MODE || all_ok) && !sys_low) begin
                    nxt_st = VOLT_MODE ? FRPS_SETL : (sys_rel ? FRPS_RAMP : FRPS_QUAL);
                end
            end
            FRPS_QUAL: begin
                if (!en_ok || !all_ok) begin
                    nxt_st = FRPS_IDLE;
                end else if (tm_hit) begin
                    nxt_st = FRPS_RAMP;
                end
            end
            FRPS_RAMP: begin
                if (&on_ff) begin
                    nxt_st = FRPS_SETL;
                end
            end
            FRPS_SETL: begin
                if (!en_ok) begin
                    nxt_st = FRPS_OFF;
                end else if (!VOLT_MODE && tm_hit && all_full) begin
                    nxt_st = FRPS_RUN;
                end
            end
            FRPS_RUN: begin
                if (!en_ok) begin
                    nxt_st = FRPS_OFF;
                end
            end
            FRPS_OFF: begin
                if (&low_s && &off_latch_ff) begin
                    nxt_st = FRPS_IDLE;
                end
            end
            FRPS_FLT: begin
                // The line is still low on entry to here, so its release edge must be caught here
                if (!VOLT_MODE && sys_rel && en_ok && all_ok) begin
                    nxt_st = FRPS_RAMP;
                end else begin
                    nxt_st = FRPS_IDLE;
                end
            end
            default: nxt_st = FRPS_IDLE;
        endcase
        if (sys_low || (!VOLT_MODE && any_flt && st_ff != FRPS_IDLE && st_ff != FRPS_QUAL &&
                        st_ff != FRPS_OFF)) begin
            nxt_st = FRPS_FLT;
        end
    end

    wire tm_run = (st_ff == FRPS_QUAL) ||
                  (st_ff == FRPS_SETL && (VOLT_MODE ? &on_ff : 1'b1) && all_full);

    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff    <= FRPS_IDLE;
            tm_ff    <= '0;
            sys_d_ff <= 1'b1;
        end else begin
            st_ff    <= nxt_st;
            tm_ff    <= (tm_run && nxt_st == st_ff) ? tm_ff + 1'b1 : '0;
            sys_d_ff <= sys_s;
        end
    end

    // ****************************************
    // Per-channel drive control
    // ****************************************
    generate
        for (g = 0; g < CH; g++) begin : g_drv
            wire kill  = (nxt_st == FRPS_FLT) || (st_ff == FRPS_FLT);
            wire v_on  = VOLT_MODE && en_ok && rail_s[g] && (st_ff == FRPS_SETL ||
                         st_ff == FRPS_RUN);
            wire t_on  = !VOLT_MODE && on_done[g];
            wire v_drp = VOLT_MODE && rail_flt[g] && st_ff != FRPS_OFF;
            always_ff @(posedge clk) begin
                if (reset) begin
                    on_ff[g]        <= 1'b0;
                    off_latch_ff[g] <= 1'b0;
                    strong_ff[g]    <= 1'b0;
                end else begin
                    if (kill || v_drp || st_ff == FRPS_IDLE) begin
                        on_ff[g] <= 1'b0;
                    end else if (t_on || v_on) begin
                        on_ff[g] <= 1'b1;
                    end else if (off_done[g]) begin
                        on_ff[g] <= 1'b0;
                    end
                    off_latch_ff[g] <= (st_ff == FRPS_OFF) && (off_latch_ff[g] || off_done[g]);
                    strong_ff[g]    <= kill || v_drp ||
                                       (off_latch_ff[g] && low_s[g]);
                end
            end
        end
    endgenerate

    // ****************************************
    // Output registers
    // ****************************************
    wire rel = (st_ff == FRPS_SETL) && tm_hit && all_full;
    always_ff @(posedge clk) begin
        if (reset) begin
            done_n_ff        <= 1'b0;
            sdn_ff           <= 1'b0;
        end else begin
            if (nxt_st == FRPS_FLT || nxt_st == FRPS_OFF || nxt_st == FRPS_IDLE ||
                (VOLT_MODE && rail_flt != '0)) begin
                done_n_ff <= 1'b0;
            end else if (rel || st_ff == FRPS_RUN) begin
                done_n_ff <= 1'b1;
            end
            sdn_ff <= !VOLT_MODE && any_flt && (st_ff == FRPS_RUN || st_ff == FRPS_SETL ||
                      st_ff == FRPS_RAMP);
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            drive_on                 <= '0;
            drive_weak_off           <= '0;
            drive_strong_off         <= '0;
            logic_out                <= '0;
            logic_out_oe             <= '1;
            seq_done_n               <= 1'b0;
            shared_shutdown_line_out <= 1'b0;
            shared_shutdown_line_oe  <= 1'b0;
            sleep                    <= 1'b0;
        end else begin
            // Open-drain option reuses the same sequencing, only the output stage differs
            drive_on                 <= OPEN_DRAIN ? '0 : on_ff;
            drive_weak_off           <= OPEN_DRAIN ? '0 : (~on_ff & ~strong_ff);
            drive_strong_off         <= OPEN_DRAIN ? '0 : (~on_ff & strong_ff);
            logic_out                <= '0;
            logic_out_oe             <= OPEN_DRAIN ? ~on_ff : '0;
            seq_done_n               <= done_n_ff;
            shared_shutdown_line_out <= 1'b0;
            shared_shutdown_line_oe  <= sdn_ff;
            sleep                    <= EN_ACT_HIGH && !en_s && st_ff == FRPS_IDLE;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_fault_kills: assert property (@(posedge clk) disable iff (reset)
        (st_ff == FRPS_FLT) |-> ##2 (drive_on == '0 && !seq_done_n))
        else $error("fault did not kill drives");
    a_sys_kills: assert property (@(posedge clk) disable iff (reset)
        (sys_low && st_ff == FRPS_RUN) |=> ##2 (drive_on == '0))
        else $error("shutdown line did not kill drives");
    a_qual_first: assert property (@(posedge clk) disable iff (reset)
        (st_ff == FRPS_QUAL && nxt_st == FRPS_RAMP) |-> tm_hit)
        else $error("ramp started before qualification");
    a_off_drops_done: assert property (@(posedge clk) disable iff (reset)
        (st_ff == FRPS_OFF) |=> ##1 !seq_done_n)
        else $error("complete not low in shutdown");
    a_done_needs_full: assert property (@(posedge clk) disable iff (reset)
        $rose(done_n_ff) |-> $past(all_full))
        else $error("complete released before drives full");
    a_latch_hold: assert property (@(posedge clk) disable iff (reset)
        (off_latch_ff[0] && st_ff == FRPS_OFF) |=> off_latch_ff[0])
        else $error("turn-off latch lost");
    a_strong_low: assert property (@(posedge clk) disable iff (reset)
        (off_latch_ff[1] && low_s[1] && st_ff == FRPS_OFF) |=> strong_ff[1])
        else $error("strong pull-down not engaged");
    a_on_order: assert property (@(posedge clk) disable iff (reset)
        (!VOLT_MODE && $rose(on_ff[2])) |-> $past(on_done[2]))
        else $error("channel on without its delay");
    c_run: cover property (@(posedge clk) disable iff (reset) st_ff == FRPS_RUN);
    c_fault: cover property (@(posedge clk) disable iff (reset) st_ff == FRPS_FLT);
    c_off: cover property (@(posedge clk) disable iff (reset)
        st_ff == FRPS_OFF ##1 st_ff == FRPS_IDLE);
endmodule
`default_nettype wire

// ### verif/frps_gate_model.sv
`timescale 1ns/100ps
`default_nettype none
module frps_gate_model
    import frps_pkg::*;
#(
    parameter int DIV = 1
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    // Drive controls
    input  wire logic [CH-1:0] drive_on,
    input  wire logic [CH-1:0] drive_weak_off,
    input  wire logic [CH-1:0] drive_strong_off,
    // Gate status
    output var  logic [CH-1:0] drive_at_full,
    output var  logic [CH-1:0] drive_below_low
);
    // ***********
    // Gate levels
    // ***********
    // Level 8 is the pumped level; DIV above 1 gives a slow gate
    logic [3:0] lvl_ff [CH];
    int         div_ff;
    always_ff @(posedge clk) begin
        div_ff <= reset ? 0 : (div_ff + 1) % DIV;
        for (int i = 0; i < CH; i++) begin
            if (reset || drive_strong_off[i]) begin
                lvl_ff[i] <= (lvl_ff[i] > 4'h4 && !reset) ? lvl_ff[i] - 4'h4 : 4'h0;
            end else if (div_ff == 0 && drive_weak_off[i] && lvl_ff[i] != 4'h0) begin
                lvl_ff[i] <= lvl_ff[i] - 4'h1;
            end else if (div_ff == 0 && drive_on[i] && lvl_ff[i] != 4'h8) begin
                lvl_ff[i] <= lvl_ff[i] + 4'h1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < CH; i++) begin
            drive_at_full[i]   = lvl_ff[i] == 4'h8;
            drive_below_low[i] = lvl_ff[i] < 4'h2;
        end
    end
endmodule
`default_nettype wire

// ### verif/test_frps_seq.sv
`timescale 1ns/100ps
`default_nettype none
module test_frps_seq
    import frps_pkg::*;
;
    // *******
    // Signals
    // *******
    localparam int QN = 20;
    localparam int DN = 30;
    localparam int FN = 5;
    logic                clk, reset, en_a, en_b, sd_pull, done_a, sdoe_a, sleep_a, done_b;
    logic [CH-1:0]       rail_a, full_a, low_a, on_a, weak_a, strong_a;
    logic [CH-1:0]       rail_b, full_b, low_b, on_b, weak_b, strong_b;
    logic [CH-1:0]       lo_c, lo_oe_c;
    logic [CH*DLY_W-1:0] ton, toff;
    wire logic           sd_a;
    int                  err_total, n_checks, cyc_n;
    // Pull-up on the shared line; any party pulling low wins
    assign sd_a = ~(sdoe_a | sd_pull);
    frps_seq #(.QUAL_N(QN), .DONE_N(DN), .VDONE_N(DN), .FILT_N(FN)) i_frps_seq (
        .clk(clk), .reset(reset), .enable_pin(en_a), .rail_undervoltage_sense(rail_a),
        .shared_shutdown_line_in(sd_a), .drive_at_full(full_a), .drive_below_low(low_a),
        .turn_on_delay_ramp(ton), .turn_off_delay_ramp(toff), .drive_on(on_a),
        .drive_weak_off(weak_a), .drive_strong_off(strong_a), .logic_out(), .logic_out_oe(),
        .seq_done_n(done_a), .shared_shutdown_line_out(), .shared_shutdown_line_oe(sdoe_a),
        .sleep(sleep_a));
    // Line tied high here: a single dropped channel must not kill the others
    frps_seq #(.EN_ACT_HIGH(1'b0), .VOLT_MODE(1'b1), .QUAL_N(QN), .DONE_N(DN), .VDONE_N(DN),
        .FILT_N(FN)) i_frps_seq_b (
        .clk(clk), .reset(reset), .enable_pin(en_b), .rail_undervoltage_sense(rail_b),
        .shared_shutdown_line_in(1'b1), .drive_at_full(full_b), .drive_below_low(low_b),
        .turn_on_delay_ramp(ton), .turn_off_delay_ramp(toff), .drive_on(on_b),
        .drive_weak_off(weak_b), .drive_strong_off(strong_b), .logic_out(), .logic_out_oe(),
        .seq_done_n(done_b), .shared_shutdown_line_out(), .shared_shutdown_line_oe(),
        .sleep());
    // Open-drain, active-low build fed the inverted enable: it shadows the first sequencer
    frps_seq #(.EN_ACT_HIGH(1'b0), .OPEN_DRAIN(1'b1), .QUAL_N(QN), .DONE_N(DN), .VDONE_N(DN),
        .FILT_N(FN)) i_frps_seq_c (
        .clk(clk), .reset(reset), .enable_pin(~en_a), .rail_undervoltage_sense(rail_a),
        .shared_shutdown_line_in(sd_a), .drive_at_full(full_a), .drive_below_low(low_a),
        .turn_on_delay_ramp(ton), .turn_off_delay_ramp(toff), .drive_on(),
        .drive_weak_off(), .drive_strong_off(), .logic_out(lo_c), .logic_out_oe(lo_oe_c),
        .seq_done_n(), .shared_shutdown_line_out(), .shared_shutdown_line_oe(),
        .sleep());
    frps_gate_model i_frps_gate_model (.clk(clk), .reset(reset), .drive_on(on_a),
        .drive_weak_off(weak_a), .drive_strong_off(strong_a), .drive_at_full(full_a),
        .drive_below_low(low_a));
    frps_gate_model #(.DIV(3)) i_frps_gate_model_b (.clk(clk), .reset(reset), .drive_on(on_b),
        .drive_weak_off(weak_b), .drive_strong_off(strong_b), .drive_at_full(full_b),
        .drive_below_low(low_b));
    // *******
    // Helpers
    // *******
    function automatic bit cnt();
        n_checks++;
        return 1'b1;
    endfunction
    function automatic int dly(input logic [CH*DLY_W-1:0] v, input int i);
        return int'(v[i*DLY_W +: DLY_W]);
    endfunction
    task automatic bad(input string m);
        err_total++;
        $display("unexpected at %0t ns: %s", $time, m);
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // *********
    // Scenarios
    // *********
    // Qualification lies between qmin and qmax cycles
    task automatic seq_on(input int t0, input int qmin, input int qmax);
        int t_on[CH];
        int t_f;
        t_on = '{-1, -1, -1, -1};
        t_f = -1;
        repeat (400) begin
            @(negedge clk);
            for (int i = 0; i < CH; i++)
                if (t_on[i] < 0 && on_a[i] === 1'b1) t_on[i] = cyc_n;
            if (t_f < 0 && on_a === 4'hf && full_a === 4'hf) t_f = cyc_n;
            if (t_f >= 0 && done_a === 1'b1) break;
        end
        for (int i = 0; i < CH; i++) begin
            if (cnt() && (t_on[i] - t0 < qmin + dly(ton, i))) bad("on early");
            if (cnt() && (t_on[i] - t0 > qmax + dly(ton, i) + 12)) bad("on late");
            if (cnt() && (t_on[i] - t_on[1] != dly(ton, i) - dly(ton, 1))) bad("spacing");
        end
        if (cnt() && (t_f < 0 || cyc_n - t_f < DN || cyc_n - t_f > DN + 10)) bad("done");
        if (cnt() && sleep_a !== 1'b0) bad("asleep");
        if (cnt() && (lo_oe_c !== ~on_a || lo_c !== 4'h0)) bad("open-drain outputs");
    endtask
    task automatic glitch_fault();
        bit s_all, s_oe;
        s_all = 1'b0;
        s_oe = 1'b0;
        @(posedge clk);
        rail_a[2] <= 1'b0;
        repeat (FN - 3) @(posedge clk);
        rail_a[2] <= 1'b1;
        tick(10);
        if (cnt() && (on_a !== 4'hf || done_a !== 1'b1 || sdoe_a !== 1'b0))
            bad("short dip faulted");
        @(posedge clk);
        rail_a[2] <= 1'b0;
        repeat (FN + 12) begin
            @(negedge clk);
            s_all |= (strong_a === 4'hf);
            s_oe |= (sdoe_a === 1'b1);
        end
        if (cnt() && !(s_all && s_oe)) bad("fault drive");
        if (cnt() && (on_a !== 4'h0 || done_a !== 1'b0)) bad("fault outputs");
        @(posedge clk);
        rail_a[2] <= 1'b1;
        seq_on(cyc_n, 0, QN);
    endtask
    task automatic line_kill();
        @(posedge clk);
        sd_pull <= 1'b1;
        tick(8);
        if (cnt() && (on_a !== 4'h0 || done_a !== 1'b0)) bad("line low ignored");
        @(posedge clk);
        sd_pull <= 1'b0;
        seq_on(cyc_n, 0, 0);
    endtask
    task automatic seq_off();
        int t_w[CH];
        int t_s[CH];
        bit late;
        t_w = '{-1, -1, -1, -1};
        t_s = '{-1, -1, -1, -1};
        late = 1'b0;
        @(posedge clk);
        en_a <= 1'b0;
        repeat (300) begin
            @(negedge clk);
            late |= (weak_a !== 4'h0 && done_a !== 1'b0);
            for (int i = 0; i < CH; i++) begin
                if (t_w[i] < 0 && weak_a[i] === 1'b1) t_w[i] = cyc_n;
                if (t_s[i] < 0 && strong_a[i] === 1'b1) t_s[i] = cyc_n;
            end
        end
        if (cnt() && late) bad("done not first");
        for (int i = 0; i < CH; i++) begin
            if (cnt() && (t_w[i] - t_w[2] != dly(toff, i) - dly(toff, 2))) bad("off order");
            if (cnt() && (t_w[i] < 0 || t_s[i] <= t_w[i])) bad("strong first");
        end
        if (cnt() && (on_a !== 4'h0 || sleep_a !== 1'b1)) bad("not off asleep");
        if (cnt() && lo_oe_c !== 4'hf) bad("open-drain not off");
    endtask
    task automatic volt_mode();
        @(posedge clk);
        en_b <= 1'b0;
        rail_b <= 4'h1;
        tick(12);
        if (cnt() && on_b !== 4'h1) bad("not independent");
        @(posedge clk);
        rail_b <= 4'hf;
        repeat (100) begin
            @(negedge clk);
            if (full_b === 4'hf) break;
        end
        tick(DN);
        if (cnt() && done_b !== 1'b0) bad("done early");
        tick(12);
        if (cnt() && done_b !== 1'b1) bad("done late");
        @(posedge clk);
        rail_b[2] <= 1'b0;
        tick(FN + 10);
        if (cnt() && (on_b !== 4'hb || done_b !== 1'b0)) bad("channel drop");
        @(posedge clk);
        rail_b[2] <= 1'b1;
        en_b <= 1'b1;
        tick(12);
        if (cnt() && done_b !== 1'b0) bad("done not latched");
        tick(150);
        if (cnt() && on_b !== 4'h0) bad("drives left on");
    endtask
    // ****
    // Main
    // ****
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc_n <= cyc_n + 1;
    // Whole run needs under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad("watchdog expired");
        close_out();
    end
    initial begin
        reset = 1'b1;
        en_a = 1'b0;
        en_b = 1'b1;
        sd_pull = 1'b0;
        rail_a = 4'h0;
        rail_b = 4'h0;
        err_total = 0;
        n_checks = 0;
        ton = {24'h19, 24'h46, 24'h0a, 24'h28};
        toff = {24'h23, 24'h0c, 24'h32, 24'h14};
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        tick(6);
        if (cnt() && sleep_a !== 1'b1) bad("awake while disabled");
        @(posedge clk);
        en_a <= 1'b1;
        rail_a <= 4'hf;
        seq_on(cyc_n, QN, QN);
        glitch_fault();
        line_kill();
        seq_off();
        volt_mode();
        close_out();
    end
endmodule
`default_nettype wire
